// *** verilog/fbs_pkg.sv ***
// Shared constants: register map, field positions, reset values and timing
package fbs_pkg;

  // Register byte offsets on the Wishbone slave
  localparam int unsigned ADDR_W                = 8;
  localparam logic [7:0]  OFS_ALIAS_SRC         = 8'h00;
  localparam logic [7:0]  OFS_ERR_LIMIT         = 8'h04;
  localparam logic [7:0]  OFS_LOST_LINK_TIMEOUT = 8'h08;
  localparam logic [7:0]  OFS_SW_VERSION        = 8'h0c;
  localparam logic [7:0]  OFS_EXT_SETUP_EIGHT   = 8'h10;
  localparam logic [7:0]  OFS_EXT_SETUP_FIVE    = 8'h14;
  localparam logic [7:0]  OFS_LATCH_FALL_COMP   = 8'h18;
  localparam logic [7:0]  OFS_ALIAS_HIGH_BYTE   = 8'h1c;
  localparam logic [7:0]  OFS_EXT_SETUP_THREE   = 8'h20;
  localparam logic [7:0]  OFS_LATCH_PRIM_COMP   = 8'h24;
  localparam logic [7:0]  OFS_IRQ_STATUS        = 8'h28;
  localparam logic [7:0]  OFS_IRQ_MASK          = 8'h2c;
  localparam logic [7:0]  OFS_NODE_STATUS       = 8'h30;

  // Reset values
  localparam logic [15:0] RST_ALIAS_SRC         = 16'h0000;
  localparam logic [15:0] RST_ERR_LIMIT         = 16'h0003;
  localparam logic [15:0] RST_LOST_LINK_TIMEOUT = 16'h0000;
  localparam logic [15:0] RST_EXT_SETUP_EIGHT   = 16'h0000;
  localparam logic [15:0] RST_EXT_SETUP_FIVE    = 16'h0c00;
  localparam logic [15:0] RST_EXT_SETUP_THREE   = 16'h3010;
  localparam logic [15:0] RST_COMP              = 16'h0000;
  localparam logic [7:0]  RST_ALIAS_HIGH_BYTE   = 8'h00;
  localparam logic [2:0]  RST_IRQ_MASK          = 3'h0;

  // Field positions and widths
  localparam int unsigned ERR_LIMIT_W           = 4;
  localparam int unsigned LOST_LINK_W           = 15;
  localparam int unsigned EXT5_OT_EXCLUDE_BIT   = 13;
  localparam int unsigned EXT3_COMP_SELECT_BIT  = 5;
  localparam int unsigned VER_DIGITS_W          = 12;
  localparam int unsigned VER1_LSB              = 16;
  localparam int unsigned VER2_LSB              = 0;
  localparam int unsigned IRQ_W                 = 3;
  localparam int unsigned IRQ_COMM_ERR_BIT      = 0;
  localparam int unsigned IRQ_LOST_LINK_BIT     = 1;
  localparam int unsigned IRQ_LATCH_BIT         = 2;
  localparam int unsigned PORTS                 = 2;

  // Alias source selections
  localparam logic [15:0] ALIAS_FROM_SWITCH     = 16'h0000;
  localparam logic [15:0] ALIAS_FROM_SII        = 16'h0001;

  // Timing
  localparam int unsigned CLK_PERIOD_NS         = 40;
  localparam int unsigned LOST_LINK_UNIT_NS     = 1000000;
  localparam int unsigned MS_CYCLES             = LOST_LINK_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned COMP_STEP_NS          = 25;
  localparam logic signed [15:0] COMP_LIMIT     = 16'sh07d0;

endpackage

// *** verilog/fbs_link_if.sv ***
// Carrier between register bank and lost link supervisor
interface fbs_link_if;
  import fbs_pkg::*;
  logic [LOST_LINK_W-1:0] timeout;
  logic                   init_to_preop;
  logic [PORTS-1:0]       lost;
  logic                   alarm_evt;
  logic                   armed;
  modport ctl (output timeout, init_to_preop, lost, input alarm_evt, armed);
  modport sup (input timeout, init_to_preop, lost, output alarm_evt, armed);
endinterface

// *** verilog/fbs_link_sup.sv ***
// Lost link supervisor: per-port millisecond timers armed by Init to PreOP
module fbs_link_sup
  import fbs_pkg::*;
#(
  parameter int unsigned MS_CYC = fbs_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Supervision link
  fbs_link_if.sup   lnk
);
  import fbs_pkg::*;

  localparam int unsigned CW = $clog2(MS_CYC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(MS_CYC - 1);

  typedef struct packed {
    logic                               armed;
    logic [PORTS-1:0]                   excl;
    logic [PORTS-1:0][CW-1:0]           cyc;
    logic [PORTS-1:0][LOST_LINK_W-1:0]  ms;
    logic                               evt;
  } fbs_sup_t;

  fbs_sup_t st;
  fbs_sup_t next_st;

  always_comb begin
    next_st     = st;
    next_st.evt = 1'b0;
    if (lnk.init_to_preop) begin
      next_st.armed = 1'b1;
      next_st.excl  = lnk.lost;
      next_st.cyc   = '0;
      next_st.ms    = '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (!st.armed || !lnk.lost[p] || st.excl[p] || lnk.timeout == '0) begin
          next_st.cyc[p] = '0;
          next_st.ms[p]  = '0;
        end else if (st.ms[p] != lnk.timeout) begin
          if (st.cyc[p] == CYC_LAST) begin
            next_st.cyc[p] = '0;
            next_st.ms[p]  = st.ms[p] + 1'b1;
            // Fires once per episode; counter then rests at the limit
            if (st.ms[p] + 1'b1 == lnk.timeout) begin
              next_st.evt = 1'b1;
            end
          end else begin
            next_st.cyc[p] = st.cyc[p] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lnk.alarm_evt = st.evt;
  assign lnk.armed     = st.armed;

endmodule

// *** verilog/fbs_node.sv ***
// Fieldbus node supervision parameter bank with Wishbone slave
// What this block does
// - Alias source: 0 switch+high, 1 SII, 2 reserved
// - Error limit bits 3..0 are the alarm threshold
// - Lost link beyond timeout after PreOP raises alarm
// - Ports already lost at transition are excluded
// - Zero timeout disables the lost link alarm
// - Version word holds two three-digit hex versions
// - Version bits 31..28 and 15..12 read zero
// - Setup five bit 13 drops overtravel from follows
// - Falling compensation signed, 25 ns steps, +-2000
// - Falling compensation used only when select set
// - Photocoupler on is rising, off is falling edge
// - Select clear: primary compensation for both edges
// - High byte parameter gives upper alias byte
module fbs_node
  import fbs_pkg::*;
#(
  parameter int unsigned       MS_CYC  = fbs_pkg::MS_CYCLES,
  parameter logic [11:0]       SW_VER1 = 12'h123, // Arbitrary value
  parameter logic [11:0]       SW_VER2 = 12'h456  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [fbs_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // Station alias
  input  wire logic [7:0]                 rotary_switch_i,
  input  wire logic [15:0]                sii_alias_i,
  output logic      [15:0]                station_alias_o,
  // Communication supervision
  input  wire logic                       comm_error_i,
  input  wire logic                       comm_good_i,
  input  wire logic                       init_to_preop_i,
  input  wire logic [fbs_pkg::PORTS-1:0]  port_lost_link_i,
  output logic                            continuous_comm_error_alarm_o,
  output logic                            lost_link_alarm_o,
  // Drive follows command qualification
  input  wire logic                       csp_mode_i,
  input  wire logic                       positive_overtravel_input_i,
  input  wire logic                       negative_overtravel_input_i,
  input  wire logic                       follows_base_i,
  output logic                            drive_follows_command_o,
  // Latch trigger
  input  wire logic                       latch_trigger_i,
  output logic                            latch_rise_o,
  output logic                            latch_fall_o,
  output logic      [15:0]                latch_comp_o,
  // Interrupt
  output logic                            irq_o
);
  import fbs_pkg::*;

  typedef struct packed {
    logic [15:0]      alias_src;
    logic [15:0]      err_limit;
    logic [15:0]      ll_timeout;
    logic [15:0]      ext8;
    logic [15:0]      ext5;
    logic [15:0]      ext3;
    logic [15:0]      comp_fall;
    logic [15:0]      comp_prim;
    logic [7:0]       alias_hi;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [3:0]       err_cnt;
    logic             err_alarm;
    logic             ll_alarm;
    logic             trig_prev;
    logic             rise;
    logic             fall;
    logic [15:0]      comp_out;
    logic [15:0]      alias_out;
    logic             follows;
    logic             ack;
    logic [31:0]      rdat;
  } fbs_state_t;

  fbs_state_t st;
  fbs_state_t next_st;

  fbs_link_if lnk ();

  fbs_link_sup #(
    .MS_CYC (MS_CYC)
  ) u_sup (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lnk   (lnk)
  );

  assign lnk.timeout       = st.ll_timeout[LOST_LINK_W-1:0];
  assign lnk.init_to_preop = init_to_preop_i;
  assign lnk.lost          = port_lost_link_i;

  // Byte-lane merge for 16-bit registers in the low half of the word
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? dat[15:8] : old_v[15:8], sel[0] ? dat[7:0] : old_v[7:0]};
  endfunction

  // Out-of-range settings are pulled to the nearest limit, not rejected
  function automatic logic [15:0] clamp_comp(input logic [15:0] v);
    if ($signed(v) > COMP_LIMIT) begin
      clamp_comp = COMP_LIMIT;
    end else if ($signed(v) < -COMP_LIMIT) begin
      clamp_comp = -COMP_LIMIT;
    end else begin
      clamp_comp = v;
    end
  endfunction

  logic             bus_req;
  logic             bus_wr;
  logic             bus_rd;
  logic [IRQ_W-1:0] evt;
  logic [31:0]      rd_mux;
  logic [31:0]      version_word;
  logic [3:0]       err_thr;
  logic [3:0]       err_inc;
  logic             ot_active;

  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    bus_wr  = bus_req && wb_we_i;
    bus_rd  = bus_req && !wb_we_i;
  end

  always_comb begin
    version_word                              = '0;
    version_word[VER1_LSB+:VER_DIGITS_W]      = SW_VER1;
    version_word[VER2_LSB+:VER_DIGITS_W]      = SW_VER2;
  end

  always_comb begin
    case (wb_adr_i)
      OFS_ALIAS_SRC:         rd_mux = {16'h0000, st.alias_src};
      OFS_ERR_LIMIT:         rd_mux = {16'h0000, st.err_limit};
      OFS_LOST_LINK_TIMEOUT: rd_mux = {16'h0000, st.ll_timeout};
      OFS_SW_VERSION:        rd_mux = version_word;
      OFS_EXT_SETUP_EIGHT:   rd_mux = {16'h0000, st.ext8};
      OFS_EXT_SETUP_FIVE:    rd_mux = {16'h0000, st.ext5};
      OFS_LATCH_FALL_COMP:   rd_mux = {16'h0000, st.comp_fall};
      OFS_ALIAS_HIGH_BYTE:   rd_mux = {24'h000000, st.alias_hi};
      OFS_EXT_SETUP_THREE:   rd_mux = {16'h0000, st.ext3};
      OFS_LATCH_PRIM_COMP:   rd_mux = {16'h0000, st.comp_prim};
      OFS_IRQ_STATUS:        rd_mux = {29'h00000000, st.irq_stat};
      OFS_IRQ_MASK:          rd_mux = {29'h00000000, st.irq_mask};
      OFS_NODE_STATUS:       rd_mux = {st.alias_out, 8'h00, lnk.armed, st.ll_alarm,
                                       st.err_alarm, 1'b0, st.err_cnt};
      default:               rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    err_thr   = st.err_limit[ERR_LIMIT_W-1:0];
    err_inc   = (st.err_cnt == 4'hf) ? st.err_cnt : st.err_cnt + 4'h1;
    ot_active = positive_overtravel_input_i || negative_overtravel_input_i;
  end

  always_comb begin
    next_st      = st;
    evt          = '0;
    next_st.ack  = bus_req;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (bus_rd) begin
      next_st.rdat = rd_mux;
    end

    // Register writes; unmapped and read-only offsets are acknowledged and ignored
    if (bus_wr) begin
      case (wb_adr_i)
        OFS_ALIAS_SRC:         next_st.alias_src  = merge16(st.alias_src, wb_dat_i, wb_sel_i);
        OFS_ERR_LIMIT:         next_st.err_limit  = merge16(st.err_limit, wb_dat_i, wb_sel_i);
        OFS_LOST_LINK_TIMEOUT: begin
          next_st.ll_timeout     = merge16(st.ll_timeout, wb_dat_i, wb_sel_i);
          next_st.ll_timeout[15] = 1'b0;
        end
        OFS_EXT_SETUP_EIGHT:   next_st.ext8       = merge16(st.ext8, wb_dat_i, wb_sel_i);
        // Reserved bits are stored as written; software keeps them at their defaults
        OFS_EXT_SETUP_FIVE:    next_st.ext5       = merge16(st.ext5, wb_dat_i, wb_sel_i);
        OFS_LATCH_FALL_COMP:   next_st.comp_fall  =
          clamp_comp(merge16(st.comp_fall, wb_dat_i, wb_sel_i));
        OFS_ALIAS_HIGH_BYTE: begin
          if (wb_sel_i[0]) begin
            next_st.alias_hi = wb_dat_i[7:0];
          end
        end
        OFS_EXT_SETUP_THREE:   next_st.ext3       = merge16(st.ext3, wb_dat_i, wb_sel_i);
        OFS_LATCH_PRIM_COMP:   next_st.comp_prim  =
          clamp_comp(merge16(st.comp_prim, wb_dat_i, wb_sel_i));
        OFS_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            next_st.irq_mask = wb_dat_i[IRQ_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // Station alias source
    case (st.alias_src)
      ALIAS_FROM_SWITCH: begin
        next_st.alias_out = {st.alias_hi, rotary_switch_i};
      end
      ALIAS_FROM_SII:    next_st.alias_out = sii_alias_i;
      default:           next_st.alias_out = 16'h0000;
    endcase

    // Consecutive error counter; a good frame restarts it, zero threshold disables
    if (comm_good_i) begin
      next_st.err_cnt = 4'h0;
    end else if (comm_error_i) begin
      next_st.err_cnt = err_inc;
      if (err_thr != 4'h0 && err_inc == err_thr && st.err_cnt != err_thr) begin
        next_st.err_alarm       = 1'b1;
        evt[IRQ_COMM_ERR_BIT]   = 1'b1;
      end
    end

    if (lnk.alarm_evt) begin
      next_st.ll_alarm         = 1'b1;
      evt[IRQ_LOST_LINK_BIT]   = 1'b1;
    end

    // Overtravel only counts against the follows flag in csp
    next_st.follows = follows_base_i &&
      !(csp_mode_i && !st.ext5[EXT5_OT_EXCLUDE_BIT] && ot_active);

    // Input high means photocoupler conducting
    next_st.trig_prev = latch_trigger_i;
    if (latch_trigger_i && !st.trig_prev) begin
      next_st.rise     = 1'b1;
      next_st.comp_out = st.comp_prim;
      evt[IRQ_LATCH_BIT] = 1'b1;
    end else if (!latch_trigger_i && st.trig_prev) begin
      next_st.fall     = 1'b1;
      next_st.comp_out = st.ext3[EXT3_COMP_SELECT_BIT] ? st.comp_fall
                                                        : st.comp_prim;
      evt[IRQ_LATCH_BIT] = 1'b1;
    end

    // Read clears status; a same-cycle event wins over the clear
    if (bus_rd && wb_adr_i == OFS_IRQ_STATUS) begin
      next_st.irq_stat = evt;
    end else begin
      next_st.irq_stat = st.irq_stat | evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  task automatic next_st_reset();
    st.alias_src  <= RST_ALIAS_SRC;
    st.err_limit  <= RST_ERR_LIMIT;
    st.ll_timeout <= RST_LOST_LINK_TIMEOUT;
    st.ext8       <= RST_EXT_SETUP_EIGHT;
    st.ext5       <= RST_EXT_SETUP_FIVE;
    st.ext3       <= RST_EXT_SETUP_THREE;
    st.comp_fall  <= RST_COMP;
    st.comp_prim  <= RST_COMP;
    st.alias_hi   <= RST_ALIAS_HIGH_BYTE;
    st.irq_stat   <= '0;
    st.irq_mask   <= RST_IRQ_MASK;
    st.err_cnt    <= '0;
    st.err_alarm  <= 1'b0;
    st.ll_alarm   <= 1'b0;
    st.trig_prev  <= 1'b0;
    st.rise       <= 1'b0;
    st.fall       <= 1'b0;
    st.comp_out   <= RST_COMP;
    st.alias_out  <= 16'h0000;
    st.follows    <= 1'b0;
    st.ack        <= 1'b0;
    st.rdat       <= 32'h00000000;
  endtask

  assign wb_ack_o                      = st.ack;
  assign wb_dat_o                      = st.rdat;
  assign station_alias_o               = st.alias_out;
  assign continuous_comm_error_alarm_o = st.err_alarm;
  assign lost_link_alarm_o             = st.ll_alarm;
  assign drive_follows_command_o       = st.follows;
  assign latch_rise_o                  = st.rise;
  assign latch_fall_o                  = st.fall;
  assign latch_comp_o                  = st.comp_out;
  assign irq_o                         = |(st.irq_stat & st.irq_mask);

endmodule

// *** verif/fbs_master_model.sv ***
// Fieldbus master model: state transitions, link status and frame outcomes
module fbs_master_model (
  // Clock
  input  wire logic                      clk_i,
  // Node side
  output logic                           init_to_preop_o,
  output logic      [fbs_pkg::PORTS-1:0] port_lost_link_o,
  output logic                           comm_error_o,
  output logic                           comm_good_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    init_to_preop_o = 1'b0;
    port_lost_link_o = '0;
    comm_error_o = 1'b0;
    comm_good_o = 1'b0;
  end

  // One frame, bad or good; the idle cycle keeps pulses distinct
  task automatic frame(input logic bad);
    @(posedge clk_i);
    comm_error_o <= bad;
    comm_good_o <= ~bad;
    @(posedge clk_i);
    comm_error_o <= 1'b0;
    comm_good_o <= 1'b0;
  endtask

  task automatic preop();
    @(posedge clk_i);
    init_to_preop_o <= 1'b1;
    @(posedge clk_i);
    init_to_preop_o <= 1'b0;
  endtask

  task automatic set_lost(input logic [fbs_pkg::PORTS-1:0] v);
    @(posedge clk_i);
    port_lost_link_o <= v;
  endtask
endmodule

// *** verif/fbs_node_asserts.sv ***
// Concurrent checks on the supervision node ports
module fbs_node_asserts
  import fbs_pkg::*;
#(
  parameter logic [11:0] SW_VER1 = 12'h000,
  parameter logic [11:0] SW_VER2 = 12'h000
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [fbs_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]                wb_dat_o,
  input  wire logic                       wb_ack_o,
  // Node signals
  input  wire logic                       latch_trigger_i,
  input  wire logic                       latch_rise_o,
  input  wire logic                       latch_fall_o,
  input  wire logic                       csp_mode_i,
  input  wire logic                       follows_base_i,
  input  wire logic                       drive_follows_command_o,
  input  wire logic                       lost_link_alarm_o,
  input  wire logic                       continuous_comm_error_alarm_o,
  input  wire logic                       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  version_value_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_SW_VERSION
    |-> wb_dat_o == {4'h0, SW_VER1, 4'h0, SW_VER2})
    else $error("version word wrong");
  version_gaps_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_SW_VERSION
    |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[15:12] == 4'h0)
    else $error("version reserved bits set");
  rise_edge_a: assert property (
    $rose(latch_trigger_i) |=> latch_rise_o && !latch_fall_o)
    else $error("rising latch edge not reported");
  fall_edge_a: assert property (
    $fell(latch_trigger_i) |=> latch_fall_o && !latch_rise_o)
    else $error("falling latch edge not reported");
  edge_quiet_a: assert property (
    $stable(latch_trigger_i) |=> !(latch_rise_o || latch_fall_o))
    else $error("latch pulse without edge");
  follow_gate_a: assert property (!follows_base_i |=> !drive_follows_command_o)
    else $error("follows flag without base condition");
  follow_plain_a: assert property (
    follows_base_i && !csp_mode_i |=> drive_follows_command_o)
    else $error("follows flag dropped outside csp");
  link_sticky_a: assert property (lost_link_alarm_o |=> lost_link_alarm_o)
    else $error("lost link alarm cleared");
  error_sticky_a: assert property (
    continuous_comm_error_alarm_o |=> continuous_comm_error_alarm_o)
    else $error("comm error alarm cleared");

  cover property ($rose(lost_link_alarm_o));
  cover property ($rose(continuous_comm_error_alarm_o));
  cover property ($fell(latch_trigger_i) ##1 latch_fall_o);
  cover property ($rose(irq_o));
endmodule

bind fbs_node fbs_node_asserts #(.SW_VER1(SW_VER1), .SW_VER2(SW_VER2)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .latch_trigger_i(latch_trigger_i), .latch_rise_o(latch_rise_o), .latch_fall_o(latch_fall_o),
  .csp_mode_i(csp_mode_i), .follows_base_i(follows_base_i),
  .drive_follows_command_o(drive_follows_command_o), .lost_link_alarm_o(lost_link_alarm_o),
  .continuous_comm_error_alarm_o(continuous_comm_error_alarm_o), .irq_o(irq_o));

// *** verif/testbench.sv ***
// Self-checking bench for the supervision node
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fbs_pkg::*;
  localparam logic [31:0] VER = {4'h0, 12'h1a2, 4'h0, 12'h3b4};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, csp = 1'b0, positive_overtravel_input = 1'b0, negot = 1'b0;
  logic        base = 1'b0, trig = 1'b0;
  logic [7:0]  adr = '0, rotary_switch = '0;
  logic [3:0]  sel = '0;
  logic [31:0] wdat = '0, rdat, q, r, seed = 32'h28fbb266;
  logic [15:0] sii = '0, alias_w, comp, e, fc;
  logic        ack, err_al, ll_al, follows, rise, fall, irq, i2p, cerr, cgood;
  logic [PORTS-1:0] lost;
  int          mismatches = 0, checks = 0, cycles = 0, v, n;
  logic [7:0]  ofs [8] = '{OFS_ALIAS_SRC, OFS_ERR_LIMIT, OFS_LOST_LINK_TIMEOUT, OFS_SW_VERSION,
                           OFS_EXT_SETUP_FIVE, OFS_EXT_SETUP_THREE, OFS_LATCH_FALL_COMP, 8'h3c};
  logic [31:0] rv [8] = '{32'(RST_ALIAS_SRC), 32'(RST_ERR_LIMIT), 32'(RST_LOST_LINK_TIMEOUT), VER,
                          32'(RST_EXT_SETUP_FIVE), 32'(RST_EXT_SETUP_THREE), 32'(RST_COMP), 32'h0};

  always #20 clk_i = ~clk_i;

  fbs_node #(.MS_CYC(10), .SW_VER1(12'h1a2), .SW_VER2(12'h3b4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rotary_switch_i(rotary_switch), .sii_alias_i(sii), .station_alias_o(alias_w),
    .comm_error_i(cerr), .comm_good_i(cgood), .init_to_preop_i(i2p), .port_lost_link_i(lost),
    .continuous_comm_error_alarm_o(err_al), .lost_link_alarm_o(ll_al), .csp_mode_i(csp),
    .positive_overtravel_input_i(positive_overtravel_input), .negative_overtravel_input_i(negot),
    .follows_base_i(base), .drive_follows_command_o(follows), .latch_trigger_i(trig),
    .latch_rise_o(rise), .latch_fall_o(fall), .latch_comp_o(comp), .irq_o(irq));

  fbs_master_model u_far (.clk_i(clk_i), .init_to_preop_o(i2p), .port_lost_link_o(lost),
    .comm_error_o(cerr), .comm_good_o(cgood));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    // No wait limit here: a hang is ended by the cycle ceiling
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] clamp(input int x);
    if (x > 2000) x = 2000;
    if (x < -2000) x = -2000;
    return x[15:0];
  endfunction

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic lat(input logic t, input logic [15:0] x);
    @(posedge clk_i);
    trig <= t;
    repeat (3) @(posedge clk_i);
    check(32'(comp), 32'(x));
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    do_reset();
    foreach (ofs[i]) begin
      wb(1'b0, ofs[i], 32'h0);
      check(q, rv[i]);
    end
    wb(1'b1, OFS_SW_VERSION, 32'hffffffff);
    wb(1'b0, OFS_SW_VERSION, 32'h0);
    check(q, VER);
    $display("test registers done");
    r = rnd();
    rotary_switch <= r[7:0];
    sii <= r[31:16];
    wb(1'b1, OFS_ALIAS_HIGH_BYTE, {24'h0, r[15:8]});
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, OFS_ALIAS_SRC, 32'(m));
      repeat (3) @(posedge clk_i);
      e = (m == 0) ? r[15:0] : (m == 1) ? r[31:16] : 16'h0;
      check(32'(alias_w), 32'(e));
    end
    $display("test alias done");
    // Reserved limit bits set on purpose: only bits 3..0 may count
    wb(1'b1, OFS_ERR_LIMIT, 32'h0000fff2);
    u_far.frame(1'b1);
    u_far.frame(1'b0);
    u_far.frame(1'b1);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(32'(err_al), 32'h0);
    u_far.frame(1'b1);
    repeat (3) @(posedge clk_i);
    check(32'(err_al), 32'h1);
    check(32'(irq), 32'h0);
    wb(1'b1, OFS_IRQ_MASK, 32'h1);
    check(32'(irq), 32'h1);
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(32'(q[IRQ_COMM_ERR_BIT]), 32'h1);
    check(32'(irq), 32'h0);
    $display("test comm errors done");
    do_reset();
    u_far.preop();
    u_far.set_lost(2'b01);
    repeat (100) @(posedge clk_i);
    check(32'(ll_al), 32'h0);
    do_reset();
    wb(1'b1, OFS_LOST_LINK_TIMEOUT, 32'h3);
    u_far.set_lost(2'b10);
    u_far.preop();
    repeat (80) @(posedge clk_i);
    check(32'(ll_al), 32'h0);
    u_far.set_lost(2'b11);
    repeat (25) @(posedge clk_i);
    check(32'(ll_al), 32'h0);
    n = 0;
    while (ll_al !== 1'b1 && n < 15) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(ll_al), 32'h1);
    $display("test lost link done");
    base <= 1'b1;
    csp <= 1'b1;
    positive_overtravel_input <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(32'(follows), 32'h0);
    wb(1'b1, OFS_EXT_SETUP_FIVE, 32'h00002c00);
    repeat (3) @(posedge clk_i);
    check(32'(follows), 32'h1);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      {base, csp, positive_overtravel_input, negot} <= r[3:0];
      wb(1'b1, OFS_EXT_SETUP_FIVE, {18'h0, r[4], 13'h0c00});
      repeat (2) @(posedge clk_i);
      check(32'(follows), 32'(r[3] && !(r[2] && !r[4] && (r[1] || r[0]))));
    end
    $display("test follows done");
    wb(1'b1, OFS_LATCH_PRIM_COMP, 32'd100);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      v = int'(r % 32'd8001) - 4000;
      wb(1'b1, OFS_LATCH_FALL_COMP, 32'(v));
      wb(1'b0, OFS_LATCH_FALL_COMP, 32'h0);
      fc = clamp(v);
      check(q, {16'h0, fc});
    end
    lat(1'b1, 16'd100);
    lat(1'b0, 16'd100);
    wb(1'b1, OFS_EXT_SETUP_THREE, 32'h00003030);
    lat(1'b1, 16'd100);
    lat(1'b0, fc);
    // Since the last reset: one lost link alarm and the latch edges
    wb(1'b0, OFS_IRQ_STATUS, 32'h0);
    check(q, 32'((1 << IRQ_LOST_LINK_BIT) | (1 << IRQ_LATCH_BIT)));
    $display("test latch done");
    end_of_test();
  end
endmodule
